// ### hw/fsp_pkg.sv
/*
 Package for the host-side flash secure-region and protection controller.
 Holds register offsets, field positions, command codes, timing counts and
 the group decode function. Assumes an APB slave and a parallel NOR flash
 driven with ordinary bus cycles.
*/
// Contract
// - Host locks the region by enter sequence then protect procedure, reset high or elevated.
// - Host issues the exit sequence before touching the rest of the array.
// - Group protect and unprotect need the elevated level on reset, ordinary bus cycles.
// - Host protects all unprotected groups before the first group-unprotect write.
package fsp_pkg;
   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0] FSP_CTRL_OFS = 8'h00;
   localparam logic [7:0] FSP_ADDR_OFS = 8'h04;
   localparam logic [7:0] FSP_WDATA_OFS = 8'h08;
   localparam logic [7:0] FSP_RDATA_OFS = 8'h0c;
   localparam logic [7:0] FSP_STAT_OFS = 8'h10;
   localparam logic [7:0] FSP_GRP_OFS = 8'h14;
   // CTRL fields: [2:0] command, [3] write-protect pin drive, [4] elevated reset
   localparam int FSP_CMD_LSB = 0;
   localparam int FSP_WP_BIT = 3;
   localparam int FSP_HV_BIT = 4;
   localparam int FSP_LOCKIND_BIT = 7;
   // Commands
   localparam logic [2:0] FSP_CMD_NONE = 3'h0;
   localparam logic [2:0] FSP_CMD_READ = 3'h1;
   localparam logic [2:0] FSP_CMD_WRITE = 3'h2;
   localparam logic [2:0] FSP_CMD_ENTER = 3'h3;
   localparam logic [2:0] FSP_CMD_EXIT = 3'h4;
   localparam logic [2:0] FSP_CMD_RESET = 3'h5;
   // Flash unlock cycles
   localparam logic [22:0] FSP_UNL_A1 = 23'h000555;
   localparam logic [22:0] FSP_UNL_A2 = 23'h0002aa;
   localparam logic [15:0] FSP_UNL_D1 = 16'h00aa;
   localparam logic [15:0] FSP_UNL_D2 = 16'h0055;
   localparam logic [15:0] FSP_ENTER_D = 16'h0088;
   localparam logic [15:0] FSP_EXIT_D = 16'h0090;
   localparam logic [15:0] FSP_EXIT2_D = 16'h0000;
   // Secure region geometry
   localparam int FSP_SEC_BYTES = 256;
   localparam logic [22:0] FSP_SERIAL_LAST = 23'h000007;
   localparam logic [22:0] FSP_SEC_LAST = 23'h00007f;
   localparam logic [7:0] FSP_LAST_GRP = 8'hff;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int FSP_CLK_MHZ = 20;
   localparam int FSP_TACC_NS = 105;
   localparam int FSP_TACC_CYC = (FSP_TACC_NS * FSP_CLK_MHZ + 999) / 1000;
   localparam int FSP_TRST_NS = 500;
   localparam int FSP_TRST_CYC = (FSP_TRST_NS * FSP_CLK_MHZ + 999) / 1000;

   // Group index of an address: single end sectors, four-sector middle groups
   function automatic logic [7:0] fsp_group(input logic [7:0] hi);
      if (hi[7:2] == 6'h00 || hi[7:2] == 6'h3f) begin
         fsp_group = hi;
      end else begin
         fsp_group = {hi[7:2], 2'b00};
      end
   endfunction : fsp_group
endpackage : fsp_pkg

// ### hw/fsp_grp_mem.sv
/*
 Small group-status memory: one bit per sector group, registered read.
 Assumes a single clock and an asynchronous active-low reset.
*/
`timescale 1ns/10ps
module fsp_grp_mem #(
   parameter int DEPTH = 256
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic we,
   input wire logic [7:0] waddr,
   input wire logic wbit,
   input wire logic [7:0] raddr,
   output logic rbit
);
   logic [DEPTH-1:0] mem_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_q <= '0;
      end else if (we) begin
         mem_q[waddr] <= wbit;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rbit <= 1'b0;
      end else begin
         rbit <= mem_q[raddr];
      end
   end
endmodule : fsp_grp_mem

// ### hw/fsp_host.sv
/*
 Host controller for a parallel NOR flash: runs read and write bus cycles,
 enter/exit secure-region sequences and hardware reset on orders from APB.
 Tracks secure-region mode and a software-kept shadow of group protection.
 Assumes the flash is asynchronous and meets a fixed access time.
*/
`timescale 1ns/10ps
module fsp_host
   import fsp_pkg::*;
#(
   parameter int ACC_CYC = FSP_TACC_CYC,
   parameter int RST_CYC = FSP_TRST_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [22:0] fl_addr,
   input wire logic [15:0] fl_dq_i,
   output logic [15:0] fl_dq_o,
   output logic fl_dq_oe,
   output logic fl_ce_n,
   output logic fl_oe_n,
   output logic fl_we_n,
   output logic fl_reset_n,
   output logic fl_reset_hv,
   output logic protect_accel_pin
);
   import fsp_pkg::*;

   typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_RST} fsp_st_t;

   fsp_st_t st_q;
   logic [22:0] addr_q;
   logic [15:0] wdata_q;
   logic [15:0] rdata_q;
   logic wp_q;
   logic hv_q;
   logic busy_q;
   logic secure_q;
   logic lockind_q;
   logic err_q;
   logic [2:0] cmd_q;
   logic [1:0] step_q;
   logic [7:0] cnt_q;
   logic is_wr_q;
   logic [7:0] grp_idx_q;
   logic grp_rbit;
   logic grp_we;
   logic [22:0] cyc_addr;
   logic [15:0] cyc_data;
   logic [1:0] last_step;
   logic blocked;
   logic wr_acc;
   logic rd_acc;

   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && penable && !pwrite;

   // ---------------------------------------------------------------
   // Write blocking: last sector under write-protect, secure region when locked
   // ---------------------------------------------------------------
   assign blocked = (!wp_q && fsp_group(addr_q[22:15]) == FSP_LAST_GRP)
      || (secure_q && lockind_q && addr_q <= FSP_SEC_LAST);
   assign grp_we = wr_acc && paddr == FSP_GRP_OFS && hv_q;

   always_comb begin
      cyc_addr = addr_q;
      cyc_data = wdata_q;
      last_step = 2'd0;
      case (cmd_q)
         FSP_CMD_ENTER, FSP_CMD_EXIT: begin
            // Three-cycle unlock; exit adds a fourth cycle
            last_step = (cmd_q == FSP_CMD_EXIT) ? 2'd3 : 2'd2;
            case (step_q)
               2'd0: begin
                  cyc_addr = FSP_UNL_A1;
                  cyc_data = FSP_UNL_D1;
               end
               2'd1: begin
                  cyc_addr = FSP_UNL_A2;
                  cyc_data = FSP_UNL_D2;
               end
               2'd2: begin
                  cyc_addr = FSP_UNL_A1;
                  cyc_data = (cmd_q == FSP_CMD_EXIT) ? FSP_EXIT_D : FSP_ENTER_D;
               end
               default: begin
                  cyc_addr = 23'h0;
                  cyc_data = FSP_EXIT2_D;
               end
            endcase
         end
         default: begin
            last_step = 2'd0;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Bus-cycle sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= ST_IDLE;
         busy_q <= 1'b0;
         cmd_q <= FSP_CMD_NONE;
         step_q <= 2'd0;
         cnt_q <= 8'h0;
         is_wr_q <= 1'b0;
         err_q <= 1'b0;
         fl_addr <= 23'h0;
         fl_dq_o <= 16'h0;
         fl_dq_oe <= 1'b0;
         fl_ce_n <= 1'b1;
         fl_oe_n <= 1'b1;
         fl_we_n <= 1'b1;
         fl_reset_n <= 1'b1;
         rdata_q <= 16'h0;
      end else begin
         case (st_q)
            ST_IDLE: begin
               if (wr_acc && paddr == FSP_CTRL_OFS && !busy_q) begin
                  cmd_q <= pwdata[FSP_CMD_LSB +: 3];
                  step_q <= 2'd0;
                  err_q <= 1'b0;
                  case (pwdata[FSP_CMD_LSB +: 3])
                     FSP_CMD_READ: begin
                        busy_q <= 1'b1;
                        is_wr_q <= 1'b0;
                        st_q <= ST_SETUP;
                     end
                     FSP_CMD_WRITE: begin
                        if (blocked) begin
                           err_q <= 1'b1;
                        end else begin
                           busy_q <= 1'b1;
                           is_wr_q <= 1'b1;
                           st_q <= ST_SETUP;
                        end
                     end
                     FSP_CMD_ENTER, FSP_CMD_EXIT: begin
                        busy_q <= 1'b1;
                        is_wr_q <= 1'b1;
                        st_q <= ST_SETUP;
                     end
                     FSP_CMD_RESET: begin
                        busy_q <= 1'b1;
                        cnt_q <= 8'h0;
                        fl_reset_n <= 1'b0;
                        st_q <= ST_RST;
                     end
                     default: begin
                        err_q <= 1'b1;
                     end
                  endcase
               end
            end
            ST_SETUP: begin
               fl_addr <= cyc_addr;
               fl_dq_o <= cyc_data;
               fl_dq_oe <= is_wr_q;
               fl_ce_n <= 1'b0;
               fl_oe_n <= is_wr_q;
               fl_we_n <= !is_wr_q;
               cnt_q <= 8'h0;
               st_q <= ST_STROBE;
            end
            ST_STROBE: begin
               cnt_q <= cnt_q + 8'h1;
               if (cnt_q >= 8'(ACC_CYC)) begin
                  if (!is_wr_q) begin
                     rdata_q <= fl_dq_i;
                  end
                  fl_we_n <= 1'b1;
                  fl_oe_n <= 1'b1;
                  st_q <= ST_HOLD;
               end
            end
            ST_HOLD: begin
               fl_ce_n <= 1'b1;
               fl_dq_oe <= 1'b0;
               if (step_q == last_step) begin
                  busy_q <= 1'b0;
                  st_q <= ST_IDLE;
               end else begin
                  step_q <= step_q + 2'd1;
                  st_q <= ST_SETUP;
               end
            end
            ST_RST: begin
               cnt_q <= cnt_q + 8'h1;
               if (cnt_q >= 8'(RST_CYC)) begin
                  fl_reset_n <= 1'b1;
                  busy_q <= 1'b0;
                  st_q <= ST_IDLE;
               end
            end
            default: begin
               st_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Secure region mode follows the sequences actually sent to the flash
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         secure_q <= 1'b0;
      end else if (st_q == ST_HOLD && step_q == last_step) begin
         if (cmd_q == FSP_CMD_ENTER) begin
            secure_q <= 1'b1;
         end else if (cmd_q == FSP_CMD_EXIT) begin
            secure_q <= 1'b0;
         end
      end else if (st_q == ST_RST) begin
         secure_q <= 1'b0;
      end
   end

   // Lock indicator is captured from bit 7 of any read made while in secure region mode, whatever the address
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lockind_q <= 1'b0;
      end else if (st_q == ST_HOLD && !is_wr_q && secure_q && cmd_q == FSP_CMD_READ) begin
         lockind_q <= rdata_q[FSP_LOCKIND_BIT];
      end
   end

   // ---------------------------------------------------------------
   // APB registers
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_q <= 23'h0;
         wdata_q <= 16'h0;
         wp_q <= 1'b1;
         hv_q <= 1'b0;
         grp_idx_q <= 8'h0;
      end else if (wr_acc) begin
         case (paddr)
            FSP_CTRL_OFS: begin
               wp_q <= pwdata[FSP_WP_BIT];
               hv_q <= pwdata[FSP_HV_BIT];
            end
            FSP_ADDR_OFS: begin
               if (!busy_q) begin
                  addr_q <= pwdata[22:0];
               end
            end
            FSP_WDATA_OFS: begin
               if (!busy_q) begin
                  wdata_q <= pwdata[15:0];
               end
            end
            FSP_GRP_OFS: begin
               grp_idx_q <= fsp_group(pwdata[15:8]);
            end
            default: begin
               grp_idx_q <= grp_idx_q;
            end
         endcase
      end
   end

   // Shadow map: pwdata[0] is the protect state of the group in pwdata[15:8]
   fsp_grp_mem #(.DEPTH(256)) u_grp (
      .pclk(pclk),
      .presetn(presetn),
      .we(grp_we),
      .waddr(fsp_group(pwdata[15:8])),
      .wbit(pwdata[0]),
      .raddr(grp_idx_q),
      .rbit(grp_rbit)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fl_reset_hv <= 1'b0;
         protect_accel_pin <= 1'b1;
      end else begin
         fl_reset_hv <= hv_q;
         // Accelerated level is never driven: only logic high or low
         protect_accel_pin <= wp_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         prdata <= 32'h0;
         if (psel && !penable && !pwrite) begin
            case (paddr)
               FSP_CTRL_OFS: prdata <= {27'h0, hv_q, wp_q, cmd_q};
               FSP_ADDR_OFS: prdata <= {9'h0, addr_q};
               FSP_WDATA_OFS: prdata <= {16'h0, wdata_q};
               FSP_RDATA_OFS: prdata <= {16'h0, rdata_q};
               FSP_STAT_OFS: prdata <= {27'h0, blocked, err_q, lockind_q, secure_q, busy_q};
               FSP_GRP_OFS: prdata <= {16'h0, grp_idx_q, 7'h0, grp_rbit};
               default: prdata <= 32'h0;
            endcase
         end
         if (psel && !penable && paddr > FSP_GRP_OFS) begin
            pslverr <= 1'b1;
         end
      end
   end
endmodule : fsp_host

// ### dv/fsp_flash_model.sv
/*
 Behavioural model of the parallel NOR flash that the host controller drives.
 Assumes the controller's strobes are glitch-free and active low.
*/
`timescale 1ns/10ps
module fsp_flash_model
   import fsp_pkg::*;
#(
   parameter int TACC_NS = 105
) (
   input wire logic lock_ind,
   input wire logic [22:0] addr,
   input wire logic [15:0] din,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic reset_n,
   output wire logic [15:0] dq
);
   logic secure_q = 1'b0;
   logic [1:0] step_q = 2'd0;
   logic [15:0] last_q = 16'h0000;
   logic [15:0] word;

   // ---------------------------------------------------------------
   // Command decode, stepped at the rising write strobe
   // ---------------------------------------------------------------
   always @(posedge we_n or negedge reset_n) begin
      if (!reset_n) begin
         secure_q <= 1'b0;
         step_q <= 2'd0;
      end else if (!ce_n) begin
         step_q <= 2'd0;
         if (step_q == 2'd0 && addr == FSP_UNL_A1 && din == FSP_UNL_D1) step_q <= 2'd1;
         if (step_q == 2'd1 && addr == FSP_UNL_A2 && din == FSP_UNL_D2) step_q <= 2'd2;
         if (step_q == 2'd2 && addr == FSP_UNL_A1 && din == FSP_ENTER_D) secure_q <= 1'b1;
         if (step_q == 2'd2 && addr == FSP_UNL_A1 && din == FSP_EXIT_D) step_q <= 2'd3;
         if (step_q == 2'd3 && din == FSP_EXIT2_D) secure_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Read path: the region overlays the whole first sector, repeating every 128 words
   // ---------------------------------------------------------------
   always_comb begin
      if (secure_q && addr[22:15] == 8'h00) begin
         word = {8'h5a, lock_ind, addr[6:0]};
      end else begin
         word = addr[15:0] ^ 16'h3c3c;
      end
   end
   // A released bus shows the inverse of the last word so stale data never matches
   always @(posedge oe_n) begin
      last_q = word;
   end
   assign #(TACC_NS) dq = (!ce_n && !oe_n) ? word : ~last_q;
endmodule : fsp_flash_model

// ### dv/fsp_host_assertions.sv
/*
 Port checker for the host controller, bound into its top module.
 Assumes one clock and the asynchronous active-low reset.
*/
`timescale 1ns/10ps
module fsp_host_assertions #(
   parameter int ACC_CYC = 3,
   parameter int RST_CYC = 10
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [22:0] fl_addr,
   input wire logic [15:0] fl_dq_i,
   input wire logic [15:0] fl_dq_o,
   input wire logic fl_dq_oe,
   input wire logic fl_ce_n,
   input wire logic fl_oe_n,
   input wire logic fl_we_n,
   input wire logic fl_reset_n,
   input wire logic fl_reset_hv,
   input wire logic protect_accel_pin
);
   int we_cnt_q;
   int rst_cnt_q;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ---------------------------------------------------------------
   // Low-time counters for the strobes
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) we_cnt_q <= 0;
      else if (fl_we_n) we_cnt_q <= 0;
      else we_cnt_q <= we_cnt_q + 1;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) rst_cnt_q <= 0;
      else if (fl_reset_n) rst_cnt_q <= 0;
      else rst_cnt_q <= rst_cnt_q + 1;
   end
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_answer;
      psel && penable && pready;
   endsequence
   a_apb_answer: assert property (s_setup |=> s_answer)
      else $error("access cycle without answer");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_ready_cause: assert property (pready |-> penable && $past(psel && !penable))
      else $error("ready without setup");
   a_err_range: assert property (pready |-> pslverr == (paddr > 8'h14))
      else $error("slave error wrong");
   a_no_contention: assert property (!fl_oe_n |-> !fl_dq_oe && fl_we_n)
      else $error("read while driving");
   a_write_cycle: assert property ($fell(fl_we_n) |-> !fl_ce_n && fl_oe_n && fl_dq_oe)
      else $error("bad write cycle");
   a_write_hold: assert property (!fl_we_n && $past(!fl_we_n) |-> $stable(fl_addr) && $stable(fl_dq_o))
      else $error("write data moved");
   a_strobe_width: assert property ($rose(fl_we_n) |-> we_cnt_q >= ACC_CYC + 1)
      else $error("write strobe short");
   a_reset_width: assert property ($rose(fl_reset_n) |-> rst_cnt_q == RST_CYC + 1)
      else $error("reset pulse length");
   a_wp_block: assert property ($fell(fl_we_n) && fl_addr[22:15] == 8'hff |-> protect_accel_pin)
      else $error("last sector written while protected");
endmodule : fsp_host_assertions

bind fsp_host fsp_host_assertions #(.ACC_CYC(ACC_CYC), .RST_CYC(RST_CYC)) u_chk (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
   .pslverr, .fl_addr, .fl_dq_i, .fl_dq_o, .fl_dq_oe, .fl_ce_n, .fl_oe_n, .fl_we_n,
   .fl_reset_n, .fl_reset_hv, .protect_accel_pin);

// ### dv/fsp_host_test.sv
/*
 Self-checking bench for the host controller with the flash model.
 Assumes the checker is bound in by its own file.
*/
`timescale 1ns/10ps
module fsp_host_test;
   import fsp_pkg::*;
   typedef struct packed {logic [31:0] exp; logic [31:0] msk; logic err;} fsp_note_t;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, lfsr = 32'h35f2;
   logic pready, pslverr, fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n, fl_reset_n, fl_reset_hv;
   logic protect_accel_pin, wp_v = 1'b1, hv_v = 1'b0, lock_v = 1'b0;
   logic [22:0] fl_addr;
   logic [15:0] fl_dq_i, fl_dq_o;
   int fail_count = 0, checks = 0, we_falls = 0, n, n0;
   fsp_note_t notes[$];
   always #25 pclk = ~pclk;
   fsp_host dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .fl_addr, .fl_dq_i, .fl_dq_o, .fl_dq_oe, .fl_ce_n, .fl_oe_n,
      .fl_we_n, .fl_reset_n, .fl_reset_hv, .protect_accel_pin);
   fsp_flash_model flash (.lock_ind(lock_v), .addr(fl_addr), .din(fl_dq_o), .ce_n(fl_ce_n),
      .oe_n(fl_oe_n),
      .we_n(fl_we_n), .reset_n(fl_reset_n), .dq(fl_dq_i));
   always @(negedge fl_we_n) if (presetn) we_falls++;
   // ---------------------------------------------------------------
   // Compare, bus and command tasks
   // ---------------------------------------------------------------
   function automatic logic [31:0] next_rand(input logic [31:0] s);
      next_rand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : next_rand
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic check_note(input fsp_note_t nt, input logic [31:0] d, input logic e);
      checks++;
      if ((d & nt.msk) !== (nt.exp & nt.msk) || e !== nt.err) begin
         fail_count++;
         $display("mismatch read expected %h/%b seen %h/%b", nt.exp, nt.err, d, e);
      end
   endtask : check_note
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : tally_and_finish
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
      if (n == 20) begin check("apb ready", 32'h1, 32'h0); tally_and_finish(); end
      rd = prdata;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb
   task automatic rd_exp(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                         input logic er);
      notes.push_back('{e, m, er});
      apb(1'b0, a, 32'h0);
   endtask : rd_exp
   task automatic cmd(input logic [2:0] c, input logic [22:0] a, input logic [15:0] d);
      int k;
      apb(1'b1, FSP_ADDR_OFS, {9'h0, a});
      apb(1'b1, FSP_WDATA_OFS, {16'h0, d});
      apb(1'b1, FSP_CTRL_OFS, {27'h0, hv_v, wp_v, c});
      for (k = 0; k < 60; k++) begin
         rd_exp(FSP_STAT_OFS, 32'h0, 32'h0, 1'b0);
         if (rd[0] === 1'b0) break;
      end
      if (k == 60) begin check("busy", 32'h0, 32'h1); tally_and_finish(); end
   endtask : cmd
   // Every read answer is matched to the oldest note
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) check_note(notes.pop_front(), prdata, pslverr);
   end
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      check("wp pin", 32'h1, 32'(protect_accel_pin));
      rd_exp(FSP_STAT_OFS, 32'h0, 32'h1f, 1'b0);
      rd_exp(FSP_GRP_OFS, 32'h0, 32'h1, 1'b0);
      rd_exp(8'h18, 32'h0, 32'h0, 1'b1);
      cmd(FSP_CMD_NONE, 23'h0, 16'h0);
      cmd(FSP_CMD_READ, 23'h3, 16'h0);
      rd_exp(FSP_RDATA_OFS, 32'h3c3f, 32'hffff, 1'b0);
      for (int i = 0; i < 4; i++) begin
         lfsr = next_rand(lfsr);
         cmd(FSP_CMD_READ, lfsr[22:0], 16'h0);
         rd_exp(FSP_RDATA_OFS, {16'h0, lfsr[15:0] ^ 16'h3c3c}, 32'hffff, 1'b0);
      end
      cmd(FSP_CMD_ENTER, 23'h0, 16'h0);
      cmd(FSP_CMD_READ, 23'h3, 16'h0);
      rd_exp(FSP_RDATA_OFS, 32'h5a03, 32'hffff, 1'b0);
      rd_exp(FSP_STAT_OFS, 32'h2, 32'h6, 1'b0);
      cmd(FSP_CMD_READ, 23'h7f, 16'h0);
      rd_exp(FSP_RDATA_OFS, 32'h5a7f, 32'hffff, 1'b0);
      cmd(FSP_CMD_EXIT, 23'h0, 16'h0);
      cmd(FSP_CMD_READ, 23'h3, 16'h0);
      rd_exp(FSP_RDATA_OFS, 32'h3c3f, 32'hffff, 1'b0);
      cmd(FSP_CMD_ENTER, 23'h0, 16'h0);
      cmd(FSP_CMD_RESET, 23'h0, 16'h0);
      cmd(FSP_CMD_READ, 23'h3, 16'h0);
      rd_exp(FSP_RDATA_OFS, 32'h3c3f, 32'hffff, 1'b0);
      wp_v = 1'b0;
      cmd(FSP_CMD_NONE, 23'h0, 16'h0);
      check("wp pin", 32'h0, 32'(protect_accel_pin));
      n0 = we_falls;
      cmd(FSP_CMD_WRITE, 23'h7f8000, lfsr[15:0]);
      rd_exp(FSP_STAT_OFS, 32'h8, 32'h8, 1'b0);
      check("flash writes", 32'h0, 32'(we_falls - n0));
      wp_v = 1'b1;
      cmd(FSP_CMD_NONE, 23'h0, 16'h0);
      cmd(FSP_CMD_WRITE, 23'h7f8000, lfsr[31:16]);
      check("flash writes", 32'h1, 32'(we_falls - n0));
      apb(1'b1, FSP_GRP_OFS, 32'h2001);
      rd_exp(FSP_GRP_OFS, 32'h0, 32'h0, 1'b0);
      rd_exp(FSP_GRP_OFS, 32'h2000, 32'hff01, 1'b0);
      hv_v = 1'b1;
      cmd(FSP_CMD_NONE, 23'h0, 16'h0);
      check("reset hv", 32'h1, 32'(fl_reset_hv));
      // Every group is protected before any unprotect write
      for (int i = 0; i < 256; i++) apb(1'b1, FSP_GRP_OFS, {16'h0, i[7:0], 8'h01});
      hv_v = 1'b0;
      cmd(FSP_CMD_NONE, 23'h0, 16'h0);
      // Without the elevated level a group write only moves the read index
      apb(1'b1, FSP_GRP_OFS, 32'h2300);
      rd_exp(FSP_GRP_OFS, 32'h2001, 32'hff01, 1'b0);
      apb(1'b1, FSP_GRP_OFS, 32'hfd00);
      rd_exp(FSP_GRP_OFS, 32'hfd01, 32'hff01, 1'b0);
      hv_v = 1'b1;
      cmd(FSP_CMD_NONE, 23'h0, 16'h0);
      apb(1'b1, FSP_GRP_OFS, 32'h2200);
      rd_exp(FSP_GRP_OFS, 32'h0, 32'h0, 1'b0);
      rd_exp(FSP_GRP_OFS, 32'h2000, 32'hff01, 1'b0);
      // Factory-locked part: region protected from the start
      lock_v = 1'b1;
      cmd(FSP_CMD_ENTER, 23'h0, 16'h0);
      cmd(FSP_CMD_READ, 23'h3, 16'h0);
      rd_exp(FSP_RDATA_OFS, 32'h5a83, 32'hffff, 1'b0);
      n0 = we_falls;
      cmd(FSP_CMD_WRITE, 23'h10, lfsr[15:0]);
      rd_exp(FSP_STAT_OFS, 32'h1e, 32'h1f, 1'b0);
      check("flash writes", 32'h0, 32'(we_falls - n0));
      cmd(FSP_CMD_EXIT, 23'h0, 16'h0);
      tally_and_finish();
   end
endmodule : fsp_host_test
